// ### logic/lacc_regs.vh
// register offsets, field positions, reset values and counts of the load-adaptive current block
`ifndef LACC_REGS_VH
`define LACC_REGS_VH

// ---------------------------------------------------------------
// register map (byte addresses on the apb bus)
// ---------------------------------------------------------------
`define LACC_OFS_CFG_WORD     12'h000
`define LACC_OFS_ADAPT_RB     12'h004
`define LACC_OFS_MEAS_RB      12'h008
`define LACC_OFS_STATUS       12'h00C

// ---------------------------------------------------------------
// selector pattern in bits 19:17 of a configuration word
// ---------------------------------------------------------------
`define LACC_SEL_HI           19
`define LACC_SEL_LO           17
`define LACC_SEL_ADAPT        3'h5
`define LACC_SEL_MEAS         3'h6

// ---------------------------------------------------------------
// load_adaptive_current_config fields
// ---------------------------------------------------------------
`define LACC_MINSEL_BIT       15
`define LACC_DECSPD_HI        14
`define LACC_DECSPD_LO        13
`define LACC_UPOFS_HI         11
`define LACC_UPOFS_LO         8
`define LACC_INCSTEP_HI       6
`define LACC_INCSTEP_LO       5
`define LACC_LOWTH_HI         3
`define LACC_LOWTH_LO         0
`define LACC_ADAPT_MASK       20'h0EF6F

// ---------------------------------------------------------------
// load_measure_and_current_scale fields
// ---------------------------------------------------------------
`define LACC_FILT_BIT         16
`define LACC_MTH_HI           14
`define LACC_MTH_LO           8
`define LACC_CSCALE_HI        4
`define LACC_CSCALE_LO        0
`define LACC_MEAS_MASK        20'h17F1F

// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define LACC_ADAPT_RST        20'h00000
`define LACC_MEAS_RST         20'h0001F
`define LACC_THR_UNIT         5
`define LACC_FILT_SAMPLES     3'h4
`define LACC_MTH_SHIFT        4

`endif

// ### logic/lacc_load_filter.v
// optional four-full-step averaging of the raw load measurement
`timescale 1ns/1ps
`default_nettype none
`include "lacc_regs.vh"

module lacc_load_filter
(
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // control
    input  wire        filt_en,
    // raw sample, taken at each full step
    input  wire        full_step,
    input  wire [9:0]  raw_value,
    // filtered result
    output reg  [9:0]  out_value_q,
    output reg         out_valid_q
);

    reg  [11:0] acc_q;
    reg  [2:0]  cnt_q;
    wire [11:0] acc_sum = acc_q + {2'h0, raw_value};

    // unfiltered passes every sample; filtered averages four full steps
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_q       <= 12'h000;
            cnt_q       <= 3'h0;
            out_value_q <= 10'h000;
            out_valid_q <= 1'b0;
        end
        else
        begin
            out_valid_q <= 1'b0;
            if (!filt_en)
            begin
                acc_q <= 12'h000;
                cnt_q <= 3'h0;
                if (full_step)
                begin
                    out_value_q <= raw_value;
                    out_valid_q <= 1'b1;
                end
            end
            else if (full_step)
            begin
                if (cnt_q == `LACC_FILT_SAMPLES - 3'h1)
                begin
                    out_value_q <= acc_sum[11:2];   // divide by four
                    out_valid_q <= 1'b1;
                    acc_q       <= 12'h000;
                    cnt_q       <= 3'h0;
                end
                else
                begin
                    acc_q <= acc_sum;
                    cnt_q <= cnt_q + 3'h1;
                end
            end
        end
    end

endmodule // lacc_load_filter
`default_nettype wire

// ### logic/lacc_thresh_adjust.v
// applies the signed measurement threshold and flags a stall
`timescale 1ns/1ps
`default_nettype none
`include "lacc_regs.vh"

module lacc_thresh_adjust
(
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // signed threshold, -64..+63
    input  wire [6:0]  threshold,
    // incoming measurement
    input  wire        in_valid,
    input  wire [9:0]  in_value,
    // adjusted measurement
    output reg  [9:0]  adj_value_q,
    output reg         adj_valid_q,
    output reg         stall_q
);

    // sign-extend and scale the threshold; lower threshold pulls the value
    // toward zero sooner, so a stall shows with less torque
    wire signed [12:0] thr_s = {{6{threshold[6]}}, threshold} <<< `LACC_MTH_SHIFT;
    wire signed [12:0] sum_s = $signed({3'h0, in_value}) + thr_s;
    wire        [9:0]  clamped = sum_s[12]                ? 10'h000 :
                                 (sum_s > 13'sd1023)      ? 10'h3FF : sum_s[9:0];

    // register the adjusted value and the stall indication
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adj_value_q <= 10'h000;
            adj_valid_q <= 1'b0;
            stall_q     <= 1'b0;
        end
        else
        begin
            adj_valid_q <= in_valid;
            if (in_valid)
            begin
                adj_value_q <= clamped;
                stall_q     <= (clamped == 10'h000);
            end
        end
    end

endmodule // lacc_thresh_adjust
`default_nettype wire

// ### logic/lacc_top.v
// load-adaptive coil current regulation with its apb configuration registers
//
// Functional notes
// - a config word with bits 19:17 = 101 loads the adaptive-current settings.
// - a config word with bits 19:17 = 110 loads measurement and scale settings.
// - bit 15 sets current floor: 0 gives half, 1 gives quarter of scale.
// - bits 14:13 pick 32, 8, 2 or 1 high samples per decrement.
// - upper threshold is (lower + offset + 1) times 32; reaching it decrements.
// - each sample below lower threshold raises current by 1, 2, 4 or 8.
// - lower threshold field zero disables regulation entirely.
// - nonzero lower field: measurement below field times 32 raises current.
// - bit 16 chooses raw samples or one averaged update per four full steps.
// - bits 14:8 hold a signed seven-bit threshold, -64 to +63.
// - lower threshold makes stall detection more sensitive.
// - five-bit scale caps the current factor; coil currents A and B are multiplied by (factor+1)/32.
`timescale 1ns/1ps
`default_nettype none
`include "lacc_regs.vh"

module lacc_top
(
    // apb clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // load measurement and step events (same clock domain)
    input  wire        full_step,
    input  wire [9:0]  load_measurement_value,
    // digital coil currents before and after scaling
    input  wire [7:0]  coil_a_in,
    input  wire [7:0]  coil_b_in,
    output reg  [7:0]  coil_a_out_q,
    output reg  [7:0]  coil_b_out_q,
    // regulation state
    output reg  [4:0]  current_factor_q,
    output reg         stall_flag_q
);

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------

    // both code tables are small constant lookups kept as functions so the
    // regulation process reads as the rule it implements
    // high samples needed per decrement
    function [5:0] dec_need;
        input [1:0] code;
        begin
            case (code)
                2'h0:    dec_need = 6'h20;
                2'h1:    dec_need = 6'h08;
                2'h2:    dec_need = 6'h02;
                default: dec_need = 6'h01;
            endcase
        end
    endfunction

    // increment steps per low sample
    function [5:0] inc_step;
        input [1:0] code;
        begin
            case (code)
                2'h0:    inc_step = 6'h01;
                2'h1:    inc_step = 6'h02;
                2'h2:    inc_step = 6'h04;
                default: inc_step = 6'h08;
            endcase
        end
    endfunction

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    reg  [19:0] adapt_cfg_q;
    reg  [19:0] meas_cfg_q;

    wire        setup_ph  = psel & ~penable;
    wire        access_wr = psel & penable & pready & pwrite;
    wire [2:0]  wsel      = pwdata[`LACC_SEL_HI:`LACC_SEL_LO];
    wire        wr_cfg    = access_wr & (paddr == `LACC_OFS_CFG_WORD);

    // both words share one write-only port; the selector inside the word picks
    // the target, the same way the serial host addresses the device
    // selector bits route the word; reserved bits are dropped, other patterns ignored
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adapt_cfg_q <= `LACC_ADAPT_RST;
            meas_cfg_q  <= `LACC_MEAS_RST;
        end
        else if (wr_cfg)
        begin
            if (wsel == `LACC_SEL_ADAPT)
                adapt_cfg_q <= pwdata[19:0] & `LACC_ADAPT_MASK;
            if (wsel == `LACC_SEL_MEAS)
                meas_cfg_q  <= pwdata[19:0] & `LACC_MEAS_MASK;
        end
    end

    // the stored words are already masked, so reserved bits read back as zero
    // and never reach the regulation logic
    // field views
    wire        min_quarter = adapt_cfg_q[`LACC_MINSEL_BIT];
    wire [1:0]  dec_code    = adapt_cfg_q[`LACC_DECSPD_HI:`LACC_DECSPD_LO];
    wire [3:0]  up_ofs      = adapt_cfg_q[`LACC_UPOFS_HI:`LACC_UPOFS_LO];
    wire [1:0]  inc_code    = adapt_cfg_q[`LACC_INCSTEP_HI:`LACC_INCSTEP_LO];
    wire [3:0]  low_th      = adapt_cfg_q[`LACC_LOWTH_HI:`LACC_LOWTH_LO];
    wire        filt_en     = meas_cfg_q[`LACC_FILT_BIT];
    wire [6:0]  meas_th     = meas_cfg_q[`LACC_MTH_HI:`LACC_MTH_LO];
    wire [4:0]  cscale      = meas_cfg_q[`LACC_CSCALE_HI:`LACC_CSCALE_LO];

    // ---------------------------------------------------------------
    // measurement path
    // ---------------------------------------------------------------
    wire [9:0]  filt_value;
    wire        filt_valid;
    wire [9:0]  sg_value;
    wire        sg_valid;
    wire        sg_stall;

    // the filter and the threshold stage each add one register, so a sample
    // reaches the regulator two edges after its full step
    // raw or four-step averaged measurement
    lacc_load_filter u_filter
    (
        .pclk        (pclk),
        .presetn     (presetn),
        .filt_en     (filt_en),
        .full_step   (full_step),
        .raw_value   (load_measurement_value),
        .out_value_q (filt_value),
        .out_valid_q (filt_valid)
    );

    // signed threshold shifts the reading before compare
    lacc_thresh_adjust u_thresh
    (
        .pclk        (pclk),
        .presetn     (presetn),
        .threshold   (meas_th),
        .in_valid    (filt_valid),
        .in_value    (filt_value),
        .adj_value_q (sg_value),
        .adj_valid_q (sg_valid),
        .stall_q     (sg_stall)
    );

    // ---------------------------------------------------------------
    // thresholds and limits
    // ---------------------------------------------------------------
    wire        reg_enable = (low_th != 4'h0);
    wire [9:0]  low_limit  = {1'b0, low_th, 5'h00};
    wire [4:0]  up_units   = {1'b0, low_th} + {1'b0, up_ofs} + 5'h01;
    wire [9:0]  up_limit   = {up_units, 5'h00};
    wire        below_low  = sg_value < low_limit;
    wire        at_or_up   = sg_value >= up_limit;

    // both limits are multiples of 32 load units; the upper one cannot wrap
    // since 15 + 15 + 1 still fits five bits
    // floor in index form: (cs+1)/2 or (cs+1)/4 levels, never below one level
    wire [5:0]  cs_levels  = {1'b0, cscale} + 6'h01;
    wire [5:0]  floor_lvl  = min_quarter ? (cs_levels >> 2) : (cs_levels >> 1);
    wire [5:0]  floor_nz   = (floor_lvl == 6'h00) ? 6'h01 : floor_lvl;
    wire [5:0]  floor_tmp  = floor_nz - 6'h01;
    wire [4:0]  floor_idx  = floor_tmp[4:0];

    // ---------------------------------------------------------------
    // current factor regulation
    // ---------------------------------------------------------------
    reg  [5:0]  dn_cnt_q;
    wire [5:0]  dn_next    = dn_cnt_q + 6'h01;
    wire [5:0]  inc_sum    = {1'b0, current_factor_q} + inc_step(inc_code);

    // the run counter only grows on consecutive high samples; a middle or low
    // sample restarts it, so a noisy load does not creep the current down
    // a low sample wins over the decrement count; limits are rechecked each cycle
    // so a lowered scale setting pulls the factor in without waiting for a sample
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            current_factor_q <= 5'h1F;
            dn_cnt_q         <= 6'h00;
            stall_flag_q     <= 1'b0;
        end
        else
        begin
            if (sg_valid)
                stall_flag_q <= sg_stall;
            if (!reg_enable)
            begin
                current_factor_q <= cscale;
                dn_cnt_q         <= 6'h00;
            end
            else if (current_factor_q > cscale)
                current_factor_q <= cscale;
            else if (current_factor_q < floor_idx)
                current_factor_q <= floor_idx;
            else if (sg_valid)
            begin
                if (below_low)
                begin
                    dn_cnt_q <= 6'h00;
                    if (inc_sum > {1'b0, cscale})
                        current_factor_q <= cscale;
                    else
                        current_factor_q <= inc_sum[4:0];
                end
                else if (at_or_up)
                begin
                    if (dn_next >= dec_need(dec_code))
                    begin
                        dn_cnt_q <= 6'h00;
                        if (current_factor_q > floor_idx)
                            current_factor_q <= current_factor_q - 5'h01;
                    end
                    else
                        dn_cnt_q <= dn_next;
                end
                else
                    dn_cnt_q <= 6'h00;                           // only a run counts
            end
        end
    end

    // ---------------------------------------------------------------
    // coil current scaling
    // ---------------------------------------------------------------
    wire [5:0]  mult    = {1'b0, current_factor_q} + 6'h01;
    wire [13:0] prod_a  = coil_a_in * mult;
    wire [13:0] prod_b  = coil_b_in * mult;

    // the product keeps bits 12:5, a plain truncation; full scale 31 returns
    // the input unchanged, so no saturation is needed here
    // (factor+1)/32 applied to both coils, registered for clean outputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            coil_a_out_q <= 8'h00;
            coil_b_out_q <= 8'h00;
        end
        else
        begin
            coil_a_out_q <= prod_a[12:5];
            coil_b_out_q <= prod_b[12:5];
        end
    end

    // ---------------------------------------------------------------
    // apb read and response
    // ---------------------------------------------------------------
    reg  [31:0] rd_mux;
    reg         rd_err;

    // status word: [4:0] factor, [5] stall, [6] regulation on, [25:16] adjusted
    // measurement; every other bit reads zero
    // decode in the setup cycle so the access cycle answers at once
    always @*
    begin
        rd_mux = 32'h00000000;
        rd_err = 1'b0;
        case (paddr)
            `LACC_OFS_CFG_WORD: rd_mux = 32'h00000000;       // write-only port
            `LACC_OFS_ADAPT_RB: rd_mux = {12'h000, adapt_cfg_q};
            `LACC_OFS_MEAS_RB:  rd_mux = {12'h000, meas_cfg_q};
            `LACC_OFS_STATUS:   rd_mux = {6'h00, sg_value, 9'h000, reg_enable,
                                          stall_flag_q, current_factor_q};
            default:            rd_err = 1'b1;
        endcase
    end

    // pready comes from a flop fed by the setup decode; the trade is a fixed
    // one-cycle access with no way to stretch it for slower sources
    // one wait-free access cycle; error and data stand only for that cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= setup_ph;
            pslverr <= setup_ph & rd_err;
            prdata  <= (setup_ph & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

endmodule // lacc_top
`default_nettype wire

// ### dv/lacc_sva.sv
// port-level assertions for the load-adaptive current block
`timescale 1ns/1ps
`default_nettype none
module lacc_sva
(
    // apb side
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // regulation side
    input wire        full_step,
    input wire [7:0]  coil_a_in,
    input wire [7:0]  coil_b_in,
    input wire [7:0]  coil_a_out_q,
    input wire [7:0]  coil_b_out_q,
    input wire [4:0]  current_factor_q,
    input wire        stall_flag_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a landed write may move the factor when regulation is off
    wire       wr_acc = psel && penable && pready && pwrite;
    logic [2:0] since_q;
    // cycles since the last step or write, saturating so it never wraps
    always @(posedge pclk or negedge presetn)
        if (!presetn) since_q <= 3'h7;
        else if (full_step || wr_acc) since_q <= 3'h0;
        else if (since_q != 3'h7) since_q <= since_q + 3'h1;

    setup_gets_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    unmapped_err_a: assert property (psel && !penable |=> pslverr ==
        ($past(paddr) > 12'h00C || $past(paddr[1:0]) != 2'h0))
        else $error("wrong slave error");
    idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    coil_a_scale_a: assert property ($past(presetn) |-> {6'h0, coil_a_out_q} ==
        (({6'h0, $past(coil_a_in)} * ({9'h0, $past(current_factor_q)} + 14'h1)) >> 5))
        else $error("coil a scaling wrong");
    coil_b_scale_a: assert property ($past(presetn) |-> {6'h0, coil_b_out_q} ==
        (({6'h0, $past(coil_b_in)} * ({9'h0, $past(current_factor_q)} + 14'h1)) >> 5))
        else $error("coil b scaling wrong");
    stall_hold_a: assert property (!$past(full_step, 3) |-> $stable(stall_flag_q))
        else $error("stall moved without a sample");
    factor_cause_a: assert property ($changed(current_factor_q) |-> since_q < 3'h5)
        else $error("factor moved without cause");
endmodule // lacc_sva
bind lacc_top lacc_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .full_step(full_step),
    .coil_a_in(coil_a_in), .coil_b_in(coil_b_in), .coil_a_out_q(coil_a_out_q),
    .coil_b_out_q(coil_b_out_q), .current_factor_q(current_factor_q),
    .stall_flag_q(stall_flag_q));
`default_nettype wire

// ### dv/lacc_load_src.sv
// load-measurement source: full-step pulses carrying a load value
`timescale 1ns/1ps
`default_nettype none
module lacc_load_src
(
    // clock
    input  wire             pclk,
    // measurement towards the block
    output var logic        full_step,
    output var logic [9:0]  load_measurement_value
);
    // quiet line until the first step
    initial
    begin
        full_step = 1'b0;
        load_measurement_value = 10'h000;
    end
    // one step; the value is not held afterwards, so a stale read shows
    task automatic step(input logic [9:0] v);
        @(posedge pclk);
        full_step <= 1'b1;
        load_measurement_value <= v;
        @(posedge pclk);
        full_step <= 1'b0;
        load_measurement_value <= ~v;
    endtask
endmodule // lacc_load_src
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the load-adaptive current block
`timescale 1ns/1ps
`default_nettype none
`include "lacc_regs.vh"
module tb;
    localparam logic [11:0] CW = `LACC_OFS_CFG_WORD;
    localparam logic [11:0] ST = `LACC_OFS_STATUS;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  ca = 8'h00;
    logic [7:0]  cb = 8'h00;
    logic [7:0]  ca_d = 8'h00;
    logic [31:0] r;
    logic        e;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         fstep;
    wire  [9:0]  load_v;
    wire  [7:0]  coil_a;
    wire  [4:0]  factor;
    wire         stall;
    integer      errors = 0;
    integer      samples_checked = 0;
    integer      seed = 32'h5954;

    lacc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .full_step(fstep),
        .load_measurement_value(load_v), .coil_a_in(ca), .coil_b_in(cb),
        .coil_a_out_q(coil_a), .coil_b_out_q(), .current_factor_q(factor),
        .stall_flag_q(stall));
    lacc_load_src src (.pclk(pclk), .full_step(fstep), .load_measurement_value(load_v));

    always #2.5 pclk = ~pclk;
    // random coil magnitudes every cycle; ca_d is what the block saw
    always @(posedge pclk)
    begin
        ca <= 8'($random(seed));
        cb <= 8'($random(seed));
        ca_d <= ca;
    end

    task automatic test_done;
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; ready and the answer are taken at one rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16)
        begin
            n = n + 1;
            @(posedge pclk);
        end
        if (n == 16)
        begin
            errors = errors + 1;
            test_done;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // a step, then the fixed latency of the regulation path
    task automatic samp(input logic [9:0] v);
        src.step(v);
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask
    function automatic logic [31:0] adw(input logic m, input logic [1:0] k,
        input logic [3:0] o, input logic [1:0] u, input logic [3:0] l);
        return {12'h0, 3'h5, 1'b0, m, k, 1'b0, o, 1'b0, u, 1'b0, l};
    endfunction
    function automatic logic [31:0] mw(input logic f, input logic [6:0] t,
        input logic [4:0] c);
        return {12'h0, 3'h6, f, 1'b0, t, 3'h0, c};
    endfunction
    function automatic integer floor_of(input integer cs, input logic m);
        integer f;
        f = (cs + 1) >> (m ? 2 : 1);
        return (f == 0) ? 0 : f - 1;
    endfunction
    function automatic integer adj_of(input logic [9:0] v, input integer t);
        integer s;
        s = v;
        s = s + t * 16;
        return (s < 0) ? 0 : (s > 1023) ? 1023 : s;
    endfunction

    initial
    begin : main
        integer cs, k, n, i, t, l, o;
        logic [31:0] w;
        logic [31:0] s;
        logic [9:0]  av;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ST, 0);
        chk(r[6:0], 7'h1F);
        apb(0, `LACC_OFS_MEAS_RB, 0);
        chk(r, `LACC_MEAS_RST);
        // stored fields, ignored selectors, read-only and unmapped places
        for (i = 0; i < 4; i++)
        begin
            w = $random(seed) & `LACC_ADAPT_MASK | 32'hA0000;
            s = $random(seed) & `LACC_MEAS_MASK | 32'hC0000;
            s[14:13] = 2'b00;
            apb(1, CW, w);
            apb(1, CW, s);
            apb(1, CW, $random(seed) | 32'hE0000);
            apb(1, `LACC_OFS_ADAPT_RB, 32'hFFFFF);
            apb(0, `LACC_OFS_ADAPT_RB, 0);
            chk(r, w & `LACC_ADAPT_MASK);
            apb(0, `LACC_OFS_MEAS_RB, 0);
            chk(r, s & `LACC_MEAS_MASK);
            apb(0, 12'h010, 0);
            chk(e, 1'b1);
        end
        // regulation off: factor follows the scale and scales coil A
        cs = $random(seed) & 31;
        apb(1, CW, mw(0, 0, cs));
        apb(1, CW, adw(1, 3, 15, 3, 0));
        samp(0);
        chk(factor, cs);
        chk(coil_a, (ca_d * (cs + 1)) >> 5);
        // each decrement speed, floor, middle band and step size
        for (k = 0; k < 4; k++)
        begin
            cs = ($random(seed) & 15) + 16;
            l = ($random(seed) & 3) + 1;
            o = $random(seed) & 3;
            n = (k == 0) ? 32 : (k == 1) ? 8 : (k == 2) ? 2 : 1;
            apb(1, CW, mw(0, 0, cs));
            apb(1, CW, adw(k[0], k[1:0], o, 3, l));
            repeat (4) samp(0);
            chk(factor, cs);
            apb(1, CW, adw(k[0], k[1:0], o, k[1:0], l));
            apb(0, ST, 0);
            chk(r[6], 1'b1);
            repeat (n - 1) samp(10'((l + o + 1) * 32));
            chk(factor, cs);
            samp(10'((l + o + 1) * 32));
            chk(factor, cs - 1);
            repeat (n * 32) samp(10'h3FF);
            chk(factor, floor_of(cs, k[0]));
            samp(10'(l * 32));
            chk(factor, floor_of(cs, k[0]));
            samp(10'(l * 32 - 1));
            t = floor_of(cs, k[0]) + (1 << k);
            chk(factor, (t > cs) ? cs : t);
        end
        // four-step averaging counted from the filter enable
        apb(1, CW, adw(0, 0, 0, 0, 0));
        apb(1, CW, mw(0, 0, 31));
        samp(10'h007);
        apb(1, CW, mw(1, 0, 31));
        t = 0;
        for (i = 0; i < 4; i++)
        begin
            av = 10'($random(seed));
            t = t + av;
            samp(av);
            apb(0, ST, 0);
            chk(r[25:16], (i == 3) ? (t >> 2) : 7);
        end
        // signed threshold, kept at or above -10, with the stall corner first
        for (i = 0; i < 6; i++)
        begin
            t = (i == 0) ? -10 : ($random(seed) & 63) - 10;
            av = (i == 0) ? 10'h064 : 10'($random(seed));
            apb(1, CW, mw(0, t[6:0], 31));
            samp(av);
            apb(0, ST, 0);
            chk(r[25:16], adj_of(av, t));
            chk(r[5], adj_of(av, t) == 0);
        end
        test_done;
    end
endmodule // tb
`default_nettype wire
